// ---- rtl/ads_seq.sv ----
// Purpose : successive-approximation conversion sequencer with APB registers
// Assumes : comp_i is high when the held level is at or above dac_o
// Notes   : APB answers in the second access cycle
// Function
// RULE1: each conversion takes at least twelve bit periods before completion.
// RULE2: clock select picks 8, 32 or 64 oscillator periods, or RC.
// RULE3: software keeps the bit period at 1.6 us or longer.
// RULE4: after completion wait two bit periods with hold capacitor disconnected.
// RULE5: hold capacitor is never discharged between conversions.
// RULE6: clearing go during a conversion aborts it at once.
// RULE7: an abort leaves the result register pair untouched.
// RULE8: after abort wait two bit periods, then acquire again unaided; with the RC clock the first of them may be partial.
// RULE9: first segment lasts one instruction cycle up to one bit period; with the RC clock it can last up to three cycles longer.
// RULE10: software powers the converter on before setting go separately.
// RULE11: software waits the acquisition time before setting go.
// RULE12: completion clears go and sets the conversion done flag.
// RULE13: port read returns zero for pins configured as analog.
// RULE14: an output-driven selected pin has its own level converted.
// RULE15: digital-input selected pins are converted normally.
// RULE16: sequencing ignores pin direction bits entirely.
// RULE17: software uses the RC clock above 1 MHz only in sleep.
// RULE18: justify bit picks right or left placement, six bits zero.
// RULE19: channel select field in bits 7 to 4 routes one input.
// RULE20: oscillator divider free-runs and restarts on each new start.
// RULE21: software may write the result pair unless a result lands.
`timescale 1ns/1ps
`include "ads_params.svh"

module ads_seq (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  input  wire logic        rc_tick_i,
  input  wire logic        comp_i,
  input  wire logic [15:0] pin_level_i,
  output logic [9:0]       dac_o,
  output logic [3:0]       chan_sel_o,
  output logic             hold_connect_o,
  output logic             conv_power_o,
  output logic             vref_ext_o
);
  import ads_pkg::*;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  ads_state_type  state, next_state;
  ads_clksel_type clk_sel, next_clk_sel;
  logic        go, next_go;
  logic        justify, next_justify;
  logic [2:0]  pcfg, next_pcfg;
  logic [7:0]  res_lo, next_res_lo;
  logic [7:0]  res_hi, next_res_hi;
  logic        done_flag, next_done_flag;
  logic [9:0]  sar, next_sar;
  logic [9:0]  mask, next_mask;
  logic [3:0]  tad_cnt, next_tad_cnt;
  logic [2:0]  first_cnt, next_first_cnt;
  logic [3:0]  next_chan;
  logic        next_power, next_vref, next_hold;
  logic        next_pready, next_pslverr;
  logic [31:0] next_prdata;
  logic [15:0] analog_mask;
  logic        tad_tick, restart, done_evt, abort_evt;
  logic        wr, rd_phase;

  // ==========================================================
  // bit period ticks
  ads_tad_gen u_tad (
    .ref_clk_i  (ref_clk_i),
    .nrst_i     (nrst_i),
    .restart_i  (restart),
    .clk_sel_i  (clk_sel),
    .rc_tick_i  (rc_tick_i),
    .tad_tick_o (tad_tick)
  );

  // ==========================================================
  // analog pin map: code 7 makes every pin digital
  for (genvar i = 0; i < 16; i++) begin : g_amask
    assign analog_mask[i] = (pcfg != 3'h7) && ((3'(7 - (i % 8))) >= pcfg);
  end

  assign wr       = psel_i && penable_i && pready_o && pwrite_i;
  assign rd_phase = psel_i && penable_i && !pready_o;

  // ==========================================================
  // next values
  always_comb begin
    next_state     = state;
    next_clk_sel   = clk_sel;
    next_go        = go;
    next_justify   = justify;
    next_pcfg      = pcfg;
    next_res_lo    = res_lo;
    next_res_hi    = res_hi;
    next_done_flag = done_flag;
    next_sar       = sar;
    next_mask      = mask;
    next_tad_cnt   = tad_cnt;
    next_first_cnt = first_cnt;
    next_chan      = chan_sel_o;
    next_power     = conv_power_o;
    next_vref      = vref_ext_o;
    restart        = 1'b0;
    done_evt       = 1'b0;
    abort_evt      = 1'b0;

    // bus answer, one wait cycle so read data come from a flop
    next_pready  = rd_phase;
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (rd_phase) begin
      unique case (paddr_i)
        `ADS_OFF_CTRL:   next_prdata = {24'h000000, chan_sel_o, 1'b0, go, 1'b0, conv_power_o};
        `ADS_OFF_CFG:    next_prdata = {24'h000000, clk_sel, justify, 1'b0, pcfg, vref_ext_o};
        `ADS_OFF_RES_LO: next_prdata = {24'h000000, res_lo};
        `ADS_OFF_RES_HI: next_prdata = {24'h000000, res_hi};
        `ADS_OFF_FLAG:   next_prdata = {31'h0000_0000, done_flag};
        `ADS_OFF_PORT:   next_prdata = {16'h0000, pin_level_i & ~analog_mask}; // RULE13
        default:         next_pslverr = 1'b1;
      endcase
      if (pwrite_i) begin
        next_prdata = 32'h0000_0000;
      end
    end

    if (wr) begin
      unique case (paddr_i)
        `ADS_OFF_CTRL: begin
          next_chan  = pwdata_i[`ADS_CTRL_CH_HI:`ADS_CTRL_CH_LO]; // RULE19
          next_go    = pwdata_i[`ADS_CTRL_GO];
          next_power = pwdata_i[`ADS_CTRL_POWER];
        end
        `ADS_OFF_CFG: begin
          next_clk_sel = ads_clksel_type'(pwdata_i[`ADS_CFG_CS_HI:`ADS_CFG_CS_LO]); // RULE2
          next_justify = pwdata_i[`ADS_CFG_JUST];
          next_pcfg    = pwdata_i[`ADS_CFG_PCFG_HI:`ADS_CFG_PCFG_LO];
          next_vref    = pwdata_i[`ADS_CFG_VREF];
        end
        `ADS_OFF_RES_LO: next_res_lo = pwdata_i[7:0]; // RULE21
        `ADS_OFF_RES_HI: next_res_hi = pwdata_i[7:0]; // RULE21
        `ADS_OFF_FLAG: begin
          if (pwdata_i[`ADS_FLAG_DONE]) begin
            next_done_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // sequencer; pin direction never enters here
    unique case (state) // RULE14 RULE15 RULE16
      ADS_OFF: begin
        if (conv_power_o) begin
          next_state = ADS_ACQ;
        end
      end
      ADS_ACQ: begin
        if (go) begin
          restart        = 1'b1; // RULE20
          next_first_cnt = 3'h0;
          next_state     = ADS_FIRST;
        end
      end
      ADS_FIRST: begin
        if (first_cnt != 3'h7) begin
          next_first_cnt = first_cnt + 3'h1;
        end
        if (!go) begin
          abort_evt    = 1'b1; // RULE6
          next_tad_cnt = 4'h0;
          next_state   = ADS_WAIT;
        end else if (tad_tick && (first_cnt >= 3'(`ADS_TCY_CYC - 1))) begin // RULE9
          next_tad_cnt = 4'h0;
          next_sar     = 10'h200;
          next_mask    = 10'h200;
          next_state   = ADS_CONV;
        end
      end
      ADS_CONV: begin
        if (!go) begin
          // partial sample is dropped, result pair keeps its value
          abort_evt    = 1'b1; // RULE6 RULE7
          next_tad_cnt = 4'h0;
          next_state   = ADS_WAIT;
        end else if (tad_tick) begin
          next_tad_cnt = tad_cnt + 4'h1;
          if (tad_cnt < `ADS_SAR_BITS) begin
            next_sar  = (comp_i ? sar : (sar & ~mask)) | (mask >> 1);
            next_mask = mask >> 1;
          end
          if (tad_cnt == `ADS_CONV_TADS - 4'h1) begin // RULE1
            done_evt       = 1'b1;
            next_go        = 1'b0; // RULE12
            next_done_flag = 1'b1; // RULE12
            next_tad_cnt   = 4'h0;
            next_state     = ADS_WAIT;
            if (justify) begin // RULE18
              next_res_hi = {6'h00, sar[9:8]};
              next_res_lo = sar[7:0];
            end else begin
              next_res_hi = sar[9:2];
              next_res_lo = {sar[1:0], 6'h00};
            end
          end
        end
      end
      ADS_WAIT: begin
        if (tad_tick) begin
          next_tad_cnt = tad_cnt + 4'h1;
          if (tad_cnt == `ADS_RECOVER_TADS - 4'h1) begin // RULE4 RULE8
            next_state = ADS_ACQ;
          end
        end
      end
    endcase

    // divider restarts at an abort so the recovery wait is two whole bit periods in the divided settings; RC ticks are not realigned
    if (abort_evt) begin
      restart = 1'b1; // RULE8
    end

    // power off aborts whatever runs, no flag unless the last bit period ends in that same cycle
    if (!conv_power_o) begin
      next_state = ADS_OFF;
    end
    // capacitor only switched, never discharged; keeps charge to next sample
    next_hold = (next_state == ADS_ACQ); // RULE4 RULE5 RULE8
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state          <= ADS_OFF;
      clk_sel        <= ADS_CS_DIV8;
      go             <= 1'b0;
      justify        <= 1'b0;
      pcfg           <= 3'h0;
      res_lo         <= `ADS_RST_RES;
      res_hi         <= `ADS_RST_RES;
      done_flag      <= 1'b0;
      sar            <= 10'h000;
      mask           <= 10'h000;
      tad_cnt        <= 4'h0;
      first_cnt      <= 3'h0;
      chan_sel_o     <= 4'h0;
      conv_power_o   <= 1'b0;
      vref_ext_o     <= 1'b0;
      hold_connect_o <= 1'b0;
      pready_o       <= 1'b0;
      prdata_o       <= 32'h0000_0000;
      pslverr_o      <= 1'b0;
    end else begin
      state          <= next_state;
      clk_sel        <= next_clk_sel;
      go             <= next_go;
      justify        <= next_justify;
      pcfg           <= next_pcfg;
      res_lo         <= next_res_lo;
      res_hi         <= next_res_hi;
      done_flag      <= next_done_flag;
      sar            <= next_sar;
      mask           <= next_mask;
      tad_cnt        <= next_tad_cnt;
      first_cnt      <= next_first_cnt;
      chan_sel_o     <= next_chan;
      conv_power_o   <= next_power;
      vref_ext_o     <= next_vref;
      hold_connect_o <= next_hold;
      pready_o       <= next_pready;
      prdata_o       <= next_prdata;
      pslverr_o      <= next_pslverr;
    end
  end

  assign dac_o = sar;

  // ==========================================================
  // checks
  logic [3:0] conv_ticks;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv_ticks <= 4'h0;
    end else if (state != ADS_CONV) begin
      conv_ticks <= 4'h0;
    end else if (tad_tick && conv_ticks != 4'hf) begin
      conv_ticks <= conv_ticks + 4'h1;
    end
  end

  sequence abort_seq;
    (state == ADS_CONV || state == ADS_FIRST) && !go && conv_power_o;
  endsequence

  conv_length_a: assert property (done_evt |-> conv_ticks == 4'd11 && tad_tick) // RULE1
    else $error("conversion ended before twelve bit periods");
  recover_open_a: assert property (state == ADS_WAIT |-> !hold_connect_o) // RULE4
    else $error("hold capacitor connected during recovery");
  recover_done_a: assert property ( // RULE8
    (state == ADS_WAIT && tad_tick && tad_cnt == 4'h1 && conv_power_o)
    |=> state == ADS_ACQ && hold_connect_o)
    else $error("acquisition did not restart after recovery");
  abort_keep_a: assert property (abort_seq |=> state == ADS_WAIT // RULE6
    && $stable(res_lo) && $stable(res_hi) && done_flag == $past(done_flag)) // RULE7
    else $error("abort changed result or missed recovery");
  done_flag_a: assert property (done_evt |=> done_flag && !go) // RULE12
    else $error("completion did not set flag and clear go");
  first_seg_a: assert property ( // RULE9
    (state == ADS_FIRST && next_state == ADS_CONV)
    |-> first_cnt >= 3'(`ADS_TCY_CYC - 1) && tad_tick)
    else $error("first segment shorter than an instruction cycle");
  justify_a: assert property (done_evt && justify |=> res_hi[7:2] == 6'h00) // RULE18
    else $error("right justified result has upper bits set");
  port_mask_a: assert property ( // RULE13
    rd_phase && !pwrite_i && paddr_i == `ADS_OFF_PORT
    |=> pready_o && (prdata_o[15:0] & $past(analog_mask)) == 16'h0000)
    else $error("analog pin read back as high");

endmodule // ads_seq

// ---- rtl/ads_params.svh ----
// Purpose : constants of the conversion sequencer (offsets, fields, resets, counts)
// Assumes : included by bare name from the design files
// Notes   : definitions only
`ifndef ADS_PARAMS_SVH
`define ADS_PARAMS_SVH

// ==========================================================
// register offsets (byte addresses, one aligned word each)
`define ADS_OFF_CTRL     8'h00
`define ADS_OFF_CFG      8'h04
`define ADS_OFF_RES_LO   8'h08
`define ADS_OFF_RES_HI   8'h0c
`define ADS_OFF_FLAG     8'h10
`define ADS_OFF_PORT     8'h14

// ==========================================================
// field positions
`define ADS_CTRL_POWER   0
`define ADS_CTRL_GO      2
`define ADS_CTRL_CH_LO   4
`define ADS_CTRL_CH_HI   7
`define ADS_CFG_VREF     0
`define ADS_CFG_PCFG_LO  1
`define ADS_CFG_PCFG_HI  3
`define ADS_CFG_JUST     5
`define ADS_CFG_CS_LO    6
`define ADS_CFG_CS_HI    7
`define ADS_FLAG_DONE    0

// ==========================================================
// reset values
`define ADS_RST_CTRL     8'h00
`define ADS_RST_CFG      8'h00
`define ADS_RST_RES      8'h00

// ==========================================================
// timing counts
`define ADS_CONV_TADS    4'd12
`define ADS_RECOVER_TADS 4'd2
`define ADS_SAR_BITS     4'd10
`define ADS_DIV8_LAST    6'd7
`define ADS_DIV32_LAST   6'd31
`define ADS_DIV64_LAST   6'd63
`define ADS_CLK_NS       10
`define ADS_TCY_NS       40
`define ADS_TCY_CYC      ((`ADS_TCY_NS + `ADS_CLK_NS - 1) / `ADS_CLK_NS)

`endif

// ---- rtl/ads_pkg.sv ----
// Purpose : types shared by the conversion sequencer files
// Assumes : nothing
// Notes   : one-hot sequencer states
package ads_pkg;

  typedef enum logic [4:0] {
    ADS_OFF   = 5'b00001,
    ADS_ACQ   = 5'b00010,
    ADS_FIRST = 5'b00100,
    ADS_CONV  = 5'b01000,
    ADS_WAIT  = 5'b10000
  } ads_state_type;

  typedef enum logic [1:0] {
    ADS_CS_DIV8  = 2'b00,
    ADS_CS_DIV32 = 2'b01,
    ADS_CS_DIV64 = 2'b10,
    ADS_CS_RC    = 2'b11
  } ads_clksel_type;

endpackage

// ---- rtl/ads_tad_gen.sv ----
// Purpose : bit conversion period tick generator
// Assumes : rc_tick_i is a one-cycle pulse per internal RC period, synchronous
// Notes   : tick output is registered
`timescale 1ns/1ps
`include "ads_params.svh"

module ads_tad_gen (
  input  wire logic                    ref_clk_i,
  input  wire logic                    nrst_i,
  input  wire logic                    restart_i,
  input  wire ads_pkg::ads_clksel_type clk_sel_i,
  input  wire logic                    rc_tick_i,
  output logic                         tad_tick_o
);
  import ads_pkg::*;

  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [5:0] last;
  logic       next_tick;

  // ==========================================================
  // divider
  always_comb begin
    unique case (clk_sel_i)
      ADS_CS_DIV8:  last = `ADS_DIV8_LAST;
      ADS_CS_DIV32: last = `ADS_DIV32_LAST;
      ADS_CS_DIV64: last = `ADS_DIV64_LAST;
      ADS_CS_RC:    last = 6'h00;
    endcase
    // free running, restarted at each start so the first period is whole in the divided settings; RC ticks are not realigned
    if (restart_i) begin // RULE20
      next_cnt  = 6'h00;
      next_tick = 1'b0;
    end else begin
      next_cnt  = (cnt >= last) ? 6'h00 : cnt + 6'h01; // RULE2
      next_tick = (clk_sel_i == ADS_CS_RC) ? rc_tick_i : (cnt == last);
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt        <= 6'h00;
      tad_tick_o <= 1'b0;
    end else begin
      cnt        <= next_cnt;
      tad_tick_o <= next_tick;
    end
  end

  // ==========================================================
  // checks
  div8_period_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RULE2
    (tad_tick_o && clk_sel_i == ADS_CS_DIV8 && !restart_i)
    ##1 (!restart_i && clk_sel_i == ADS_CS_DIV8)[*7] |=> tad_tick_o)
    else $error("divide-by-8 period is not eight cycles");

endmodule // ads_tad_gen

// ---- test/ads_analog_model.sv ----
// Purpose : analog side of the sequencer: channel pins, hold capacitor, comparator
// Assumes : channel levels arrive from the bench as ten-bit codes, 16 channels packed
// Notes   : held charge is kept while disconnected and is cleared only at reset
`timescale 1ns/1ps

module ads_analog_model (
  input  wire logic         ref_clk_i,
  input  wire logic         nrst_i,
  input  wire logic [159:0] ch_level_i,
  input  wire logic [3:0]   chan_sel_i,
  input  wire logic         hold_connect_i,
  input  wire logic [9:0]   dac_i,
  output logic              comp_o
);
  logic [9:0] held;

  // ==========================================================
  // hold capacitor
  // the selected pin level is taken whatever its direction, as the device sees it
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      held <= 10'h000;
    end else if (hold_connect_i) begin
      held <= ch_level_i[chan_sel_i * 10 +: 10];
    end
  end

  // ==========================================================
  // comparator: sees only the held charge, so pin changes mid-conversion cannot leak in
  assign comp_o = (held >= dac_i);
endmodule // ads_analog_model

// ---- test/tb_top.sv ----
// Purpose : self-checking bench for the conversion sequencer
// Assumes : APB slave answers within 50 cycles, rc ticks made here
// Notes   : timing windows allow for polling latency over APB
`timescale 1ns/1ps
`include "ads_params.svh"

module tb_top;
  import ads_pkg::*;
  // rc bit period of 1.6 us at 100 MHz; rc runs stand in for sleep use
  localparam int RC_DIV = 160;
  logic         ref_clk_i, nrst_i, psel, penable, pwrite, pready, pslverr;
  logic         rc_tick, comp, hold, power, vref, hold_q, err;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [9:0]   dac;
  logic [3:0]   chan;
  logic [15:0]  pins;
  logic [159:0] ch_level;
  int           cyc = 0;
  int           fall_cyc, rc_cnt, error_cnt, tests_run;

  ads_seq dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .rc_tick_i(rc_tick), .comp_i(comp),
    .pin_level_i(pins), .dac_o(dac), .chan_sel_o(chan), .hold_connect_o(hold),
    .conv_power_o(power), .vref_ext_o(vref));
  ads_analog_model pin_side (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ch_level_i(ch_level),
    .chan_sel_i(chan), .hold_connect_i(hold), .dac_i(dac), .comp_o(comp));

  // ==========================================================
  // clock, rc source and hold-capacitor monitor
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    rc_cnt <= (rc_cnt == RC_DIV - 1) ? 0 : rc_cnt + 1;
    rc_tick <= (rc_cnt == RC_DIV - 1);
    hold_q <= hold;
    if (hold_q === 1'b1 && hold === 1'b0) begin
      fall_cyc <= cyc;
    end
  end

  // ==========================================================
  // reporting
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_rng(input string name, input int lo, input int hi, input int got);
    tests_run++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask
  task automatic timeout(input string name);
    error_cnt++;
    $display("wrong value %s expected answer seen timeout", name);
    wrap_up();
  endtask

  // ==========================================================
  // bus and waits
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) timeout("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_hold(input int lim);
    int n;
    n = 0;
    while (hold !== 1'b1 && n < lim) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (hold !== 1'b1) timeout("hold_connect");
  endtask

  // ==========================================================
  // reference model
  function automatic logic [15:0] place(input logic [9:0] r, input logic rj);
    return rj ? {6'h00, r} : {r, 6'h00};
  endfunction
  function automatic logic [15:0] port_exp(input logic [15:0] p, input int code);
    logic [15:0] v;
    v = p;
    for (int i = 0; i < 16; i++) begin
      if (code != 7 && 7 - (i % 8) >= code) v[i] = 1'b0;
    end
    return v;
  endfunction

  // ==========================================================
  // scenarios
  task automatic convert(input int cs, input logic [3:0] ch, input logic [9:0] lvl,
                         input logic rj);
    int per, go_cyc, n;
    logic [15:0] e;
    per = (cs == 0) ? 8 : (cs == 1) ? 32 : (cs == 2) ? 64 : RC_DIV;
    ch_level[ch * 10 +: 10] <= lvl;
    apb(1'b1, `ADS_OFF_CFG, {24'h0, cs[1:0], rj, 4'h0, rj});
    apb(1'b1, `ADS_OFF_CTRL, {24'h0, ch, 4'h1});
    repeat (30) @(posedge ref_clk_i);
    chk("chan_sel", {28'h0, ch}, {28'h0, chan});
    chk("power_vref", {30'h0, 1'b1, rj}, {30'h0, power, vref});
    apb(1'b1, `ADS_OFF_CTRL, {24'h0, ch, 4'h5});
    go_cyc = cyc;
    n = 0;
    do begin
      apb(1'b0, `ADS_OFF_CTRL, 32'h0);
      n++;
    end while (rd[2] !== 1'b0 && n < 1000);
    if (rd[2] !== 1'b0) timeout("go_clear");
    chk_rng("conv_cycles", 12 * per + 4, 14 * per + 12, cyc - go_cyc);
    chk("ctrl_done", {24'h0, ch, 4'h1}, rd);
    chk("dac", {22'h0, lvl}, {22'h0, dac});
    wait_hold(4 * per + 20);
    chk_rng("hold_low", 14 * per + 2, 16 * per + 8, cyc - fall_cyc);
    e = place(lvl, rj);
    apb(1'b0, `ADS_OFF_RES_LO, 32'h0);
    chk("res_lo", {24'h0, e[7:0]}, rd);
    apb(1'b0, `ADS_OFF_RES_HI, 32'h0);
    chk("res_hi", {24'h0, e[15:8]}, rd);
    apb(1'b0, `ADS_OFF_FLAG, 32'h0);
    chk("done_flag", 32'h1, rd);
    apb(1'b1, `ADS_OFF_FLAG, 32'h1);
    apb(1'b0, `ADS_OFF_FLAG, 32'h0);
    chk("flag_clear", 32'h0, rd);
  endtask

  task automatic abort_run(input int dly);
    int ab;
    apb(1'b1, `ADS_OFF_CFG, 32'h0);
    apb(1'b1, `ADS_OFF_RES_LO, 32'h5a);
    apb(1'b1, `ADS_OFF_RES_HI, 32'ha5);
    repeat (30) @(posedge ref_clk_i);
    apb(1'b1, `ADS_OFF_CTRL, 32'h05);
    repeat (dly) @(posedge ref_clk_i);
    apb(1'b1, `ADS_OFF_CTRL, 32'h01);
    ab = cyc;
    wait_hold(60);
    chk_rng("abort_wait", 17, 22, cyc - ab);
    apb(1'b0, `ADS_OFF_RES_LO, 32'h0);
    chk("abort_lo", 32'h5a, rd);
    apb(1'b0, `ADS_OFF_RES_HI, 32'h0);
    chk("abort_hi", 32'ha5, rd);
    apb(1'b0, `ADS_OFF_FLAG, 32'h0);
    chk("abort_flag", 32'h0, rd);
  endtask

  initial begin
    logic [15:0] e;
    nrst_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rc_tick = 1'b0;
    rc_cnt = 0;
    ch_level = '0;
    pins = 16'h0000;
    error_cnt = 0;
    tests_run = 0;
    void'($urandom(32'h277b6b00));
    repeat (10) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    for (int a = 0; a <= 20; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk("reset_reg", 32'h0, rd);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    for (int cs = 0; cs < 4; cs++) begin
      convert(cs, 4'($urandom()), 10'($urandom()), 1'(cs));
    end
    convert(0, 4'hf, 10'h3ff, 1'b0);
    abort_run(2);
    abort_run(40);
    for (int code = 0; code < 8; code++) begin
      pins <= 16'($urandom());
      apb(1'b1, `ADS_OFF_CFG, 32'(code << 1));
      apb(1'b0, `ADS_OFF_PORT, 32'h0);
      e = port_exp(pins, code);
      chk("port", {16'h0, e}, rd);
    end
    wrap_up();
  end
endmodule // tb_top
